// >>> powerdown_serial_ctrl.sv
// Power-down, VCO control and serial output pin control of the PLL subsystem
`timescale 1ns/1ps
module powerdown_serial_ctrl
	import powerdown_serial_pkg::*;
#(
	parameter logic [23:0] VERSION_ID = 24'h00A5C3 // Arbitrary value
) (
	// Core clock and reset
	input wire logic core_clk,
	input wire logic nrst,
	// Power-down pin
	input wire logic chipEnablePin,
	// Serial port pins
	input wire logic serialClock,
	input wire logic serialDataIn,
	input wire logic serialEnableStrobe,
	output logic serialDataOut,
	output logic serialDataOe,
	// Internal signals offered for export; bit 1 is the lock indicator
	input wire logic [31:0] internalSignals,
	// PLL power controls
	output logic analogEnable,
	output logic internalClockEnable,
	output logic [5:0] blockEnable,
	output logic autocalDisable,
	// VCO controls
	output logic vcoPowerDown,
	output logic mainRfOutputEnable,
	output logic dividerOutputEnable,
	output logic highPerformance,
	output logic lowCurrent
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		mode_e mode; // Protocol decision, survives soft reset
		logic [23:0] power; // pll_power_down_control
		logic [23:0] driver; // Master enable register
		logic [23:0] cal; // Calibration register
		logic [23:0] pinmux; // output_pin_mux_config
		logic [4:0] readAddr; // Open mode read pointer
		logic [8:0] vcoReg1; // VCO register 1, only power-on reset restores it
		logic vcoDown; // VCO register 2 power-down bit
		logic addressed; // Last strobe carried our chip address
		logic strobePrev; // Strobe one cycle ago, for edge detection
		logic generalPurposeBit; // Registered exported signal
		logic powerDown; // Registered power-down decision
		logic frameToggle; // Flips on every open strobe; the link spots new frames by it
	} core_s;

	core_s state;
	core_s next_state;

	logic [2:0] syncIn;
	logic strobeS;
	logic enablePinS;
	logic clockSeenS;
	logic strobeRise;
	logic strobeFall;
	logic linkRstN;
	logic [4:0] lookupAddr;
	logic [23:0] lookupWord;
	logic [31:0] shiftWord;
	logic clockSeen;
	logic readBit;
	logic legacyReading;
	logic driveWanted;
	logic useRead;
	logic pinValue;
	logic writeValid;
	logic [4:0] writeAddr;
	logic [23:0] writeData;

	// ----------------------------------------------------------------
	// Clock domain crossings
	// ----------------------------------------------------------------

	// Pins and link flags enter the core through two flops
	sync_2ff #(.WIDTH(3)) coreSync (
		.clk(core_clk),
		.rstN(nrst),
		.d({serialEnableStrobe, !chipEnablePin, clockSeen}),
		.q(syncIn)
	);
	assign strobeS = syncIn[2];
	// Carried inverted so that flops fresh out of reset read as a running pin
	assign enablePinS = !syncIn[1];
	assign clockSeenS = syncIn[0];

	// Link reset; the link clock must tick during reset for it to reach the link
	sync_2ff #(.WIDTH(1)) linkRstSync (
		.clk(serialClock),
		.rstN(1'b1),
		.d(nrst),
		.q(linkRstN)
	);

	// The link logic runs on the serial clock; the serial port never sees power-down
	serial_link_shifter link (
		.serialClock(serialClock),
		.linkRstN(linkRstN),
		.serialDataIn(serialDataIn),
		.serialEnableStrobe(serialEnableStrobe),
		.legacySelected(state.mode == MODE_LEGACY),
		.readAddr(state.readAddr),
		.frameToggle(state.frameToggle),
		.lookupAddr(lookupAddr),
		.lookupWord(lookupWord),
		.shiftWord(shiftWord),
		.clockSeen(clockSeen),
		.readBit(readBit),
		.legacyReading(legacyReading)
	);

	// ----------------------------------------------------------------
	// Read lookup and frame decode
	// ----------------------------------------------------------------

	// Registers are quasi-static during a frame, so the link may sample this mux
	always_comb
	begin
		case (lookupAddr)
			ADDR_IDENT: lookupWord = VERSION_ID;
			ADDR_POWER: lookupWord = state.power;
			ADDR_DRIVER: lookupWord = state.driver;
			ADDR_CAL: lookupWord = state.cal;
			ADDR_PINMUX: lookupWord = state.pinmux;
			default: lookupWord = 24'h000000; // VCO registers are not readable
		endcase
	end

	assign strobeRise = strobeS && !state.strobePrev;
	assign strobeFall = !strobeS && state.strobePrev;

	// Open frames commit on the strobe rise, legacy writes on its fall
	always_comb
	begin
		writeValid = 1'b0;
		writeAddr = shiftWord[7:3];
		writeData = shiftWord[31:8];
		if (strobeRise && state.mode != MODE_LEGACY && clockSeenS)
			writeValid = (shiftWord[2:0] == CHIP_ADDRESS);
		else if (strobeFall && state.mode == MODE_LEGACY)
		begin
			// Six address bits arrive; only the low five are decoded
			writeValid = !shiftWord[30];
			writeAddr = shiftWord[28:24];
			writeData = shiftWord[23:0];
		end
	end

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.strobePrev = strobeS;
		// Protocol is fixed by whichever edge shows up first
		if (state.mode == MODE_LISTEN)
		begin
			if (clockSeenS)
				next_state.mode = MODE_OPEN;
			else if (strobeRise)
				next_state.mode = MODE_LEGACY;
		end
		// Chip address latched on each open strobe; zeros so far means us
		if (strobeRise && state.mode != MODE_LEGACY)
			next_state.addressed = (shiftWord[2:0] == CHIP_ADDRESS);
		// Tell the link that its next edge opens a frame and reloads read data
		if (strobeRise && state.mode == MODE_OPEN)
			next_state.frameToggle = !state.frameToggle;
		if (writeValid)
		begin
			case (writeAddr)
				ADDR_IDENT:
				begin
					if (writeData[IDENT_SOFT_RESET])
					begin
						// PLL registers only; mode and VCO state stay
						next_state.power = POWER_RESET;
						next_state.driver = DRIVER_RESET;
						next_state.cal = CAL_RESET;
						next_state.pinmux = PINMUX_RESET;
						next_state.readAddr = READ_ADDR_RESET;
					end
					else
						next_state.readAddr = writeData[IDENT_RADDR_MSB:0];
				end
				ADDR_POWER: next_state.power = writeData;
				ADDR_DRIVER: next_state.driver = writeData;
				ADDR_CAL: next_state.cal = writeData;
				ADDR_PINMUX: next_state.pinmux = writeData;
				ADDR_VCO_RELAY:
				begin
					// Relayed VCO writes; only power-on reset restores them
					if (writeData[RELAY_ADDR_MSB:0] == VCO_REG1)
						next_state.vcoReg1 = writeData[RELAY_DATA_LSB+8:RELAY_DATA_LSB];
					else if (writeData[RELAY_ADDR_MSB:0] == VCO_REG2)
						next_state.vcoDown = writeData[RELAY_DATA_LSB+VCO_POWER_DOWN];
				end
				default: next_state = next_state; // Unmapped writes are dropped
			endcase
		end
		// Pin control or register control of power-down
		if (state.power[POWER_PIN_SELECT])
			next_state.powerDown = !enablePinS;
		else
			next_state.powerDown = state.power[POWER_SW_DOWN];
		// Exported signal chosen by the select field
		next_state.generalPurposeBit = internalSignals[state.pinmux[PINMUX_SELECT_MSB:0]];
	end

	// Power-on reset loads every reset value, including the VCO image
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			state <= '0;
			state.mode <= MODE_LISTEN;
			state.power <= POWER_RESET;
			state.driver <= DRIVER_RESET;
			state.cal <= CAL_RESET;
			state.pinmux <= PINMUX_RESET;
			state.readAddr <= READ_ADDR_RESET;
			state.vcoReg1 <= VCO_REG1_RESET;
		end
		else
			state <= next_state;
	end

	// ----------------------------------------------------------------
	// Power and VCO outputs
	// ----------------------------------------------------------------
	assign analogEnable = !state.powerDown;
	assign internalClockEnable = !state.powerDown;
	// Bias, phase detector, charge pump, reference buffer, VCO buffer, pads
	assign blockEnable = state.powerDown ? state.power[POWER_KEEP_MSB:POWER_KEEP_LSB] : 6'h3F;
	assign autocalDisable = state.cal[CAL_AUTO_DISABLE];
	assign vcoPowerDown = state.vcoDown;
	// No separate mute on the main output; divider also needs a running VCO
	assign mainRfOutputEnable = !state.vcoDown;
	assign dividerOutputEnable = state.vcoReg1[VCO_DIV_ENABLE] && !state.vcoDown;
	assign highPerformance = (state.vcoReg1[VCO_PERF_MSB:VCO_PERF_LSB] == PERF_HIGH);
	assign lowCurrent = (state.vcoReg1[VCO_PERF_MSB:VCO_PERF_LSB] == PERF_LOW);

	// ----------------------------------------------------------------
	// Serial output pin
	// ----------------------------------------------------------------

	// An addressed read: legacy read phase, or open mode after our chip address
	assign useRead = (state.mode == MODE_LEGACY) ? legacyReading : state.addressed;
	assign driveWanted = state.pinmux[PINMUX_ALWAYS_ON] || useRead;
	assign pinValue = (useRead && !state.pinmux[PINMUX_NO_AUTOMUX]) ? readBit
		: state.generalPurposeBit;
	assign serialDataOut = pinValue;
	// Master enable beats all; disabled halves leave the line to a pull resistor
	assign serialDataOe = state.driver[DRIVER_MASTER_EN] && driveWanted
		&& (pinValue ? !state.pinmux[PINMUX_NO_PULLUP]
		: !state.pinmux[PINMUX_NO_PULLDOWN]);

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	sequence s_softWrite;
		writeValid && writeAddr == ADDR_IDENT && writeData[IDENT_SOFT_RESET];
	endsequence

	sequence s_vcoDownWrite;
		writeValid && writeAddr == ADDR_VCO_RELAY && writeData[RELAY_ADDR_MSB:0] == VCO_REG2;
	endsequence

	a_soft_keeps_mode: assert property (s_softWrite |=>
		state.mode == $past(state.mode) && state.vcoReg1 == $past(state.vcoReg1)
		&& state.power == POWER_RESET)
		else $error("soft reset changed mode or VCO state");
	a_vco_relay: assert property (s_vcoDownWrite |=>
		vcoPowerDown == $past(writeData[RELAY_DATA_LSB+VCO_POWER_DOWN]))
		else $error("relayed VCO power-down not applied");
	a_pin_powerdown: assert property (
		state.power[POWER_PIN_SELECT] && !enablePinS && $stable(state.power) |=> !analogEnable)
		else $error("low enable pin did not power down");
	a_reg_powerdown: assert property (
		!state.power[POWER_PIN_SELECT] && $stable(state.power)
		|=> analogEnable == !$past(state.power[POWER_SW_DOWN]))
		else $error("register power-down not followed");
	a_keep_on_bits: assert property (!analogEnable |->
		blockEnable == state.power[POWER_KEEP_MSB:POWER_KEEP_LSB])
		else $error("keep-on bits not honoured");
	a_master_off: assert property (!state.driver[DRIVER_MASTER_EN] |-> !serialDataOe)
		else $error("driver active while master enable clear");
	a_always_on: assert property (state.driver[DRIVER_MASTER_EN]
		&& state.pinmux[PINMUX_ALWAYS_ON] && state.pinmux[PINMUX_NO_PULLUP +: 2] == 2'b00
		|-> serialDataOe)
		else $error("always-on driver tristated");
	a_no_automux: assert property (state.pinmux[PINMUX_NO_AUTOMUX]
		|-> serialDataOut == state.generalPurposeBit)
		else $error("automux active while disabled");
	a_vco_mute: assert property (vcoPowerDown |->
		!mainRfOutputEnable && !dividerOutputEnable)
		else $error("outputs live while VCO powered down");
	a_chip_address: assert property (strobeRise && state.mode == MODE_OPEN
		&& shiftWord[2:0] != CHIP_ADDRESS |=> !state.addressed)
		else $error("foreign chip address drove the line");

endmodule

// >>> powerdown_serial_ctrl_bench.sv
// Self-checking bench for the power-down and serial output control block
`timescale 1ns/1ps
module powerdown_serial_ctrl_bench;
	import powerdown_serial_pkg::*;
	localparam logic [23:0] VERSION = 24'h5A3C21; // Arbitrary value
	logic core_clk, nrst, chipEnablePin, serialClock, serialDataIn, serialEnableStrobe;
	logic serialDataOut, serialDataOe, analogEnable, internalClockEnable, autocalDisable;
	logic vcoPowerDown, mainRfOutputEnable, dividerOutputEnable, highPerformance, lowCurrent;
	logic [31:0] internalSignals;
	logic [5:0] blockEnable;
	logic [23:0] rd;
	logic [15:0] st; // Oe,out,analog,clk,block[5:0],autocal,vcoDown,rf,div,hiPerf,lowCur
	int miscompares = 0;
	int num_checks = 0;
	assign st = {serialDataOe, serialDataOut, analogEnable, internalClockEnable, blockEnable,
		autocalDisable, vcoPowerDown, mainRfOutputEnable, dividerOutputEnable, highPerformance,
		lowCurrent};
	powerdown_serial_ctrl #(.VERSION_ID(VERSION)) dut (.core_clk(core_clk), .nrst(nrst),
		.chipEnablePin(chipEnablePin), .serialClock(serialClock), .serialDataIn(serialDataIn),
		.serialEnableStrobe(serialEnableStrobe), .serialDataOut(serialDataOut),
		.serialDataOe(serialDataOe), .internalSignals(internalSignals),
		.analogEnable(analogEnable), .internalClockEnable(internalClockEnable),
		.blockEnable(blockEnable), .autocalDisable(autocalDisable), .vcoPowerDown(vcoPowerDown),
		.mainRfOutputEnable(mainRfOutputEnable), .dividerOutputEnable(dividerOutputEnable),
		.highPerformance(highPerformance), .lowCurrent(lowCurrent));
	// An undriven line shows the host the inverse, so a read without drive fails
	serial_host_model host (.serialClock(serialClock), .serialDataIn(serialDataIn),
		.serialEnableStrobe(serialEnableStrobe),
		.serialDataOut(serialDataOe ? serialDataOut : !serialDataOut));
	// Free-running core clock
	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, miscompares);
		if (miscompares == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Compare the masked status word
	// Looked at off the edge, then back on a rising edge for the next stimulus
	task automatic chkst(input logic [15:0] m, input logic [15:0] e);
		#1;
		check({16'h0, st & m}, {16'h0, e});
		@(posedge core_clk);
	endtask
	// One frame, then time for the strobe to cross into the core
	task automatic wr(input logic [4:0] a, input logic [23:0] d, input logic [2:0] c = 3'h0);
		host.frame({d, a, c}, rd);
		repeat (8) @(posedge core_clk);
	endtask
	// Point the read address, then fetch the word on the following frame
	task automatic rdreg(input logic [4:0] a, output logic [23:0] v);
		wr(ADDR_IDENT, {19'h0, a});
		host.frame({19'h0, a, ADDR_IDENT, CHIP_ADDRESS}, v);
		repeat (8) @(posedge core_clk);
	endtask
	task automatic t_power();
		logic [23:0] v;
		wr(ADDR_POWER, 24'h0000A5);
		chipEnablePin <= 1'b0;
		repeat (8) @(posedge core_clk);
		chkst(16'h3FC0, 16'h0A40);
		rdreg(ADDR_POWER, v);
		check({8'h0, v}, 32'h0000A5);
		chipEnablePin <= 1'b1;
		wr(ADDR_POWER, 24'h000002);
		chkst(16'h3FC0, 16'h0000);
		wr(ADDR_POWER, POWER_RESET);
		chkst(16'h3FC0, 16'h3FC0);
	endtask
	task automatic t_vco();
		wr(ADDR_VCO_RELAY, {12'h0, 9'h01C, VCO_REG1});
		chkst(16'h0007, 16'h0002);
		wr(ADDR_VCO_RELAY, {12'h0, 9'h100, VCO_REG1});
		chkst(16'h0007, 16'h0005);
		wr(ADDR_CAL, 24'h000800);
		wr(ADDR_VCO_RELAY, {12'h0, 9'h008, VCO_REG2});
		chkst(16'h003C, 16'h0030);
		wr(ADDR_IDENT, 24'h000020);
		chkst(16'h003C, 16'h0010);
		wr(ADDR_VCO_RELAY, {12'h0, 9'h000, VCO_REG2});
		chkst(16'h001C, 16'h000C);
	endtask
	task automatic t_driver();
		logic [23:0] v;
		wr(ADDR_PINMUX, PINMUX_RESET, 3'h5);
		chkst(16'h8000, 16'h0000);
		wr(ADDR_PINMUX, PINMUX_RESET);
		chkst(16'h8000, 16'h8000);
		wr(ADDR_DRIVER, 24'h0);
		wr(ADDR_PINMUX, 24'h0000C1);
		chkst(16'h8000, 16'h0000);
		wr(ADDR_DRIVER, DRIVER_RESET);
		wr(ADDR_PINMUX, 24'h0000C1, 3'h5);
		internalSignals <= 32'h2;
		repeat (6) @(posedge core_clk);
		chkst(16'hC000, 16'hC000);
		wr(ADDR_PINMUX, 24'h0000C3);
		chkst(16'hC000, 16'h8000);
		wr(ADDR_PINMUX, 24'h0001C1);
		chkst(16'h8000, 16'h0000);
		internalSignals <= 32'h0;
		repeat (6) @(posedge core_clk);
		chkst(16'hC000, 16'h8000);
		wr(ADDR_PINMUX, 24'h0003C1);
		chkst(16'h8000, 16'h0000);
		wr(ADDR_PINMUX, PINMUX_RESET);
		rdreg(ADDR_IDENT, v);
		check({8'h0, v}, {8'h0, VERSION});
	endtask
	// Watchdog: 23 frames of about 5.3 us each, so 400 us leaves ample margin
	initial
	begin
		#400000;
		miscompares++;
		report_and_stop();
	end
	initial
	begin
		nrst = 1'b0;
		chipEnablePin = 1'b1;
		internalSignals = 32'h0;
		host.pulses(4);
		@(posedge core_clk);
		nrst <= 1'b1;
		host.pulses(4);
		repeat (8) @(posedge core_clk);
		chkst(16'hBFFF, 16'h3FCD);
		t_power();
		t_vco();
		t_driver();
		report_and_stop();
	end
endmodule

// >>> powerdown_serial_pkg.sv
// Package: register map, field positions, reset values and frame constants
package powerdown_serial_pkg;

	// ----------------------------------------------------------------
	// Register offsets (5-bit register address space)
	// ----------------------------------------------------------------
	localparam logic [4:0] ADDR_IDENT = 5'h00; // Read: version word, write: read address/soft reset
	localparam logic [4:0] ADDR_POWER = 5'h01; // pll_power_down_control
	localparam logic [4:0] ADDR_VCO_RELAY = 5'h05; // Relay of writes into the VCO subsystem
	localparam logic [4:0] ADDR_DRIVER = 5'h08; // Holds the serial output master enable
	localparam logic [4:0] ADDR_CAL = 5'h0A; // Holds the autocalibration disable
	localparam logic [4:0] ADDR_PINMUX = 5'h0F; // output_pin_mux_config

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int IDENT_SOFT_RESET = 5; // soft_reset_bit
	localparam int IDENT_RADDR_MSB = 4; // Open mode read address field
	localparam int POWER_PIN_SELECT = 0; // 1: chip_enable_pin controls power-down
	localparam int POWER_SW_DOWN = 1; // Power-down request when pin is ignored
	localparam int POWER_KEEP_LSB = 2; // Keep-on bits 2..7
	localparam int POWER_KEEP_MSB = 7;
	localparam int DRIVER_MASTER_EN = 5; // 0: serial output never drives
	localparam int CAL_AUTO_DISABLE = 11;
	localparam int PINMUX_SELECT_MSB = 4; // outputSignalSelect field 4..0
	localparam int PINMUX_NO_AUTOMUX = 6;
	localparam int PINMUX_ALWAYS_ON = 7;
	localparam int PINMUX_NO_PULLUP = 8;
	localparam int PINMUX_NO_PULLDOWN = 9;
	localparam int RELAY_ADDR_MSB = 2; // Relay word: VCO register address in 2..0
	localparam int RELAY_DATA_LSB = 3; // Relay word: VCO register data in 11..3
	localparam int VCO_PERF_LSB = 2; // VCO register 1: performance field 4..2
	localparam int VCO_PERF_MSB = 4;
	localparam int VCO_DIV_ENABLE = 8; // VCO register 1: divider powered
	localparam int VCO_POWER_DOWN = 3; // VCO register 2: VCO powered down

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [23:0] POWER_RESET = 24'h000001;
	localparam logic [23:0] DRIVER_RESET = 24'h000020;
	localparam logic [23:0] CAL_RESET = 24'h000000;
	localparam logic [23:0] PINMUX_RESET = 24'h000001;
	localparam logic [8:0] VCO_REG1_RESET = 9'h100;
	localparam logic [4:0] READ_ADDR_RESET = 5'h00;

	// ----------------------------------------------------------------
	// Serial frame constants
	// ----------------------------------------------------------------
	localparam logic [2:0] CHIP_ADDRESS = 3'h0; // This device answers to chip address 000b
	localparam logic [2:0] VCO_REG1 = 3'h1;
	localparam logic [2:0] VCO_REG2 = 3'h2;
	localparam logic [2:0] PERF_HIGH = 3'h7;
	localparam logic [2:0] PERF_LOW = 3'h0;
	localparam logic [5:0] LEGACY_ADDR_EDGE = 6'h06; // Count before the last address edge
	localparam logic [5:0] LEGACY_LAST_EDGE = 6'h1F; // Count held before the 32nd edge
	localparam logic [5:0] FRAME_EDGE_LIMIT = 6'h20; // Counter saturates here

	// Serial protocol decision after power-on
	typedef enum logic [1:0] {
		MODE_LISTEN = 2'b00,
		MODE_LEGACY = 2'b01,
		MODE_OPEN = 2'b10
	} mode_e;

endpackage

// >>> serial_host_model.sv
// Host model: drives open-mode serial frames and samples the returned data
`timescale 1ns/1ps
module serial_host_model (
	// Serial pins toward the device
	output logic serialClock,
	output logic serialDataIn,
	output logic serialEnableStrobe,
	// Return line from the device
	input wire logic serialDataOut
);
	// Link clock stands low between frames
	initial
	begin
		serialClock = 1'b0;
		serialDataIn = 1'b0;
		serialEnableStrobe = 1'b0;
	end
	// Bare clock pulses around reset; the first edge picks open mode
	task automatic pulses(input int n);
		repeat (n)
		begin
			#80 serialClock = 1'b1;
			#80 serialClock = 1'b0;
		end
	endtask
	// 24 data, 5 register, 3 chip address bits, MSB first
	task automatic frame(input logic [31:0] word, output logic [23:0] rd);
		#3;
		for (int i = 31; i >= 0; i--)
		begin
			serialDataIn = word[i];
			#80 serialClock = 1'b1;
			#80 serialClock = 1'b0;
			// Read data settles after the rising edge, so take it on the falling one
			if (i >= 8)
				rd[i-8] = serialDataOut;
		end
		// Hold time is over: show the inverse instead of a stale bit
		serialDataIn = ~serialDataIn;
		#20 serialEnableStrobe = 1'b1;
		#60 serialEnableStrobe = 1'b0;
		#60;
	endtask
endmodule

// >>> serial_link_shifter.sv
// Serial-clock-domain shifter: frame capture, bit counting and read data output
`timescale 1ns/1ps
module serial_link_shifter
	import powerdown_serial_pkg::*;
(
	// Link clock and its synchronised reset
	input wire logic serialClock,
	input wire logic linkRstN,
	// Serial pins (already in this domain)
	input wire logic serialDataIn,
	input wire logic serialEnableStrobe,
	// Quasi-static settings from the core
	input wire logic legacySelected,
	input wire logic [4:0] readAddr,
	input wire logic frameToggle,
	// Register lookup done by the core
	output logic [4:0] lookupAddr,
	input wire logic [23:0] lookupWord,
	// Results toward the core and the pin
	output logic [31:0] shiftWord,
	output logic clockSeen,
	output logic readBit,
	output logic legacyReading
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [31:0] shift; // Last bits shifted in, newest in bit 0
		logic [5:0] count; // Edges within the current frame
		logic [23:0] outWord; // Read data, MSB leaves first
		logic reading; // Legacy read data phase
		logic seen; // At least one link edge since reset
		logic frameAck; // Core frame toggle as seen at the last edge
	} link_s;

	link_s state;
	link_s next_state;
	logic legacyS;
	logic inFrame;
	logic newFrame;

	// Mode comes from the core domain as a level
	sync_2ff #(.WIDTH(1)) modeSync (
		.clk(serialClock),
		.rstN(linkRstN),
		.d(legacySelected),
		.q(legacyS)
	);

	// Legacy frames run while the strobe is high, open frames while it is low
	assign inFrame = (serialEnableStrobe == legacyS);

	// The toggle flips while the strobe is high and the link clock stands still,
	// so it is settled at every link edge; a difference marks an open frame's first edge
	assign newFrame = !legacyS && (frameToggle != state.frameAck);

	// Legacy reads look up the address as its last bit arrives
	assign lookupAddr = legacyS ? {state.shift[3:0], serialDataIn} : readAddr;

	// ----------------------------------------------------------------
	// Frame sequencing
	// ----------------------------------------------------------------
	always_comb
	begin
		next_state = state;
		next_state.seen = 1'b1;
		next_state.frameAck = frameToggle;
		if (!inFrame)
		begin
			// Between frames the counter restarts
			next_state.count = '0;
			next_state.reading = 1'b0;
		end
		else
		begin
			if (newFrame)
				next_state.count = 6'h01; // Open strobe seen: this is the first edge
			else if (state.count != FRAME_EDGE_LIMIT)
				next_state.count = state.count + 6'h01;
			// Legacy keeps only the first 30 bits; the 31st and 32nd edges are ignored
			if (!legacyS || state.count < LEGACY_LAST_EDGE - 6'h01)
				next_state.shift = {state.shift[30:0], serialDataIn};
			if (legacyS)
			begin
				if (state.count == LEGACY_ADDR_EDGE && state.shift[5])
				begin
					// Read bit was set: switch the pin over to data
					next_state.reading = 1'b1;
					next_state.outWord = lookupWord;
				end
				else if (state.count == LEGACY_LAST_EDGE - 6'h01)
					next_state.reading = 1'b0; // Lock signal back on the 31st edge
				else
					next_state.outWord = {state.outWord[22:0], 1'b0};
			end
			else if (state.count == 6'h00 || newFrame)
				next_state.outWord = lookupWord; // Open mode: selected register each frame
			else
				next_state.outWord = {state.outWord[22:0], 1'b0};
		end
	end

	// Register the link state
	always_ff @(posedge serialClock)
	begin
		if (!linkRstN)
			state <= '0;
		else
			state <= next_state;
	end

	assign shiftWord = state.shift;
	assign clockSeen = state.seen;
	assign readBit = state.outWord[23];
	assign legacyReading = state.reading;

endmodule

// >>> sync_2ff.sv
// Two flip-flop synchroniser for level signals entering a clock domain
`timescale 1ns/1ps
module sync_2ff #(
	parameter int WIDTH = 1
) (
	// Destination clock and its reset
	input wire logic clk,
	input wire logic rstN,
	// Level from another domain, and its synchronised copy
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [WIDTH-1:0] first; // Metastable stage, read only by the second
		logic [WIDTH-1:0] second;
	} sync_s;

	sync_s state;
	sync_s next_state;

	// Shift the level one stage per edge
	always_comb
	begin
		next_state.first = d;
		next_state.second = state.first;
	end

	// Synchronous reset to all zero
	always_ff @(posedge clk)
	begin
		if (!rstN)
			state <= '0;
		else
			state <= next_state;
	end

	assign q = state.second;

endmodule
